/* logic/cco_map.vh */
// Address map, field positions and reset values of the compare output stage.
// Included by the compare output design file, its checker and its bench.
`ifndef CCO_MAP_VH
`define CCO_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CCO_OFS_CTRL 12'h000
`define CCO_OFS_STATUS 12'h004
`define CCO_OFS_CMP1 12'h008
`define CCO_OFS_CMP2 12'h00C
`define CCO_OFS_PRESET 12'h010
`define CCO_OFS_COUNT 12'h014
`define CCO_ADDR_W 12

// ****************************************
// Control register fields
// ****************************************
`define CCO_CTRL_RST1 0
`define CCO_CTRL_RST2 1
`define CCO_CTRL_OUT_EN 2
`define CCO_CTRL_PRESET_ON_MATCH 3
`define CCO_CTRL_DET_CLR 4
`define CCO_CTRL_W 4
`define CCO_CTRL_RESET 4'h0

// ****************************************
// Status register fields
// ****************************************
`define CCO_ST_GREATER1 0
`define CCO_ST_MATCH1 1
`define CCO_ST_SMALLER1 2
`define CCO_ST_GREATER2 3
`define CCO_ST_MATCH2 4
`define CCO_ST_SMALLER2 5
`define CCO_ST_EXT_DET 6
`define CCO_ST_W 7

// ****************************************
// Data reset values
// ****************************************
`define CCO_CMP_RESET 32'h0000_0000
`define CCO_PRESET_RESET 32'h0000_0000
`define CCO_ZERO32 32'h0000_0000

`endif

/* logic/cco_compare_out.v */
// Coincidence output stage of one counter channel: two compare units,
// their flags and output signals, and the preset-on-match request.
// Assumes the count arrives synchronous to CORE_CLK from the counting
// engine, which performs the load when PRESET_LOAD pulses.
//
// Operation
// - Two independent compare units per channel
// - Compare point write stores signed value
// - Smaller flag while count below point
// - Smaller flag drops when count reaches point
// - Greater flag while count above point
// - Equal count sets match flag and output
// - Reset command holds match flag off
// - Releasing reset on equal count sets again
// - One enable gates both MATCH_OUT outputs; MATCH_EVENT is not gated
// - Match flags ignore the output enable
// - Events only on match flag rising edge
// - Greater/smaller never overlap a new match
// - Option loads preset on match 1 rise
// - Unit 2 never loads preset
// - Newest preset value used on load
// - Uncleared match 1 gives no reload
// - Phase Z detected flag blocks all loads
//
// Added by the designer: register access over APB and the address map.
`include "cco_map.vh"

module cco_compare_out #(
	parameter CW = 32
) (
	input wire CORE_CLK,
	input wire RESETN,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [`CCO_ADDR_W-1:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// Counting engine side
	input wire [CW-1:0] CUR_COUNT,
	input wire EXT_PRESET_DETECTED,
	output reg EXT_PRESET_DETECT_CLEAR,
	output reg PRESET_LOAD,
	output reg [CW-1:0] PRESET_VALUE,
	// Coincidence outputs
	output reg [1:0] MATCH_OUT,
	output reg [1:0] MATCH_EVENT
);

	// ****************************************
	// Bus decode
	// ****************************************
	wire bus_access;
	wire bus_wr;
	wire bus_rd;
	wire sel_ctrl;
	wire sel_status;
	wire sel_cmp1;
	wire sel_cmp2;
	wire sel_preset;
	wire sel_count;
	wire addr_ok;

	assign bus_access = PSEL & PENABLE;
	assign bus_wr = bus_access & PWRITE;
	assign bus_rd = bus_access & ~PWRITE;
	assign sel_ctrl = (PADDR == `CCO_OFS_CTRL);
	assign sel_status = (PADDR == `CCO_OFS_STATUS);
	assign sel_cmp1 = (PADDR == `CCO_OFS_CMP1);
	assign sel_cmp2 = (PADDR == `CCO_OFS_CMP2);
	assign sel_preset = (PADDR == `CCO_OFS_PRESET);
	assign sel_count = (PADDR == `CCO_OFS_COUNT);
	assign addr_ok = sel_ctrl | sel_status | sel_cmp1 | sel_cmp2 | sel_preset | sel_count;

	// Zero wait states; unmapped addresses and writes to read-only targets answer with an error
	wire bad_addr;
	wire ro_write;
	assign PREADY = 1'b1;
	assign bad_addr = ~addr_ok;
	assign ro_write = PWRITE & (sel_status | sel_count);
	assign PSLVERR = bus_access & (bad_addr | ro_write);

	// ****************************************
	// Control register
	// ****************************************
	reg rst_cmd_1_q;
	reg rst_cmd_2_q;
	reg out_enable_q;
	reg preset_on_match_q;
	wire ctrl_wr;
	wire [`CCO_CTRL_W-1:0] ctrl_q;
	wire rst_cmd_1;
	wire rst_cmd_2;
	wire out_enable;
	wire preset_on_match;

	localparam [`CCO_CTRL_W-1:0] CTRL_RESET = `CCO_CTRL_RESET;

	assign ctrl_wr = bus_wr & sel_ctrl;

	// One flop per command bit keeps each field's reset and write visible
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_cmd_1_q <= CTRL_RESET[`CCO_CTRL_RST1];
		end else if (ctrl_wr) begin
			rst_cmd_1_q <= PWDATA[`CCO_CTRL_RST1];
		end
	end

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_cmd_2_q <= CTRL_RESET[`CCO_CTRL_RST2];
		end else if (ctrl_wr) begin
			rst_cmd_2_q <= PWDATA[`CCO_CTRL_RST2];
		end
	end

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			out_enable_q <= CTRL_RESET[`CCO_CTRL_OUT_EN];
		end else if (ctrl_wr) begin
			out_enable_q <= PWDATA[`CCO_CTRL_OUT_EN];
		end
	end

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			preset_on_match_q <= CTRL_RESET[`CCO_CTRL_PRESET_ON_MATCH];
		end else if (ctrl_wr) begin
			preset_on_match_q <= PWDATA[`CCO_CTRL_PRESET_ON_MATCH];
		end
	end

	assign rst_cmd_1 = rst_cmd_1_q;
	assign rst_cmd_2 = rst_cmd_2_q;
	assign out_enable = out_enable_q;
	assign preset_on_match = preset_on_match_q;
	assign ctrl_q[`CCO_CTRL_RST1] = rst_cmd_1_q;
	assign ctrl_q[`CCO_CTRL_RST2] = rst_cmd_2_q;
	assign ctrl_q[`CCO_CTRL_OUT_EN] = out_enable_q;
	assign ctrl_q[`CCO_CTRL_PRESET_ON_MATCH] = preset_on_match_q;

	// Detect-clear is a write-one pulse handed to the phase Z logic
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			EXT_PRESET_DETECT_CLEAR <= 1'b0;
		end else begin
			EXT_PRESET_DETECT_CLEAR <= bus_wr & sel_ctrl & PWDATA[`CCO_CTRL_DET_CLR];
		end
	end

	// ****************************************
	// Preset value register
	// ****************************************
	wire preset_wr;

	assign preset_wr = bus_wr & sel_preset;

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PRESET_VALUE <= `CCO_PRESET_RESET;
		end else if (preset_wr) begin
			PRESET_VALUE <= PWDATA[CW-1:0];
		end
	end

	// ****************************************
	// Compare units
	// ****************************************
	wire [1:0] unit_sel;
	wire [1:0] unit_rst;
	wire [1:0] greater_flag;
	wire [1:0] match_flag;
	wire [1:0] smaller_flag;
	wire [1:0] match_rise;
	wire [2*CW-1:0] cmp_point;

	assign unit_sel = {sel_cmp2, sel_cmp1};
	assign unit_rst = {rst_cmd_2, rst_cmd_1};

	genvar u;
	generate
		for (u = 0; u < 2; u = u + 1) begin : g_unit
			reg [CW-1:0] cmp_q;
			reg greater_q;
			reg smaller_q;
			reg match_q;
			wire cmp_wr;
			wire count_eq;
			wire count_gt;
			wire count_lt;
			wire greater_d;
			wire smaller_d;
			wire match_d;
			wire out_d;
			wire event_d;

			// Compare point write
			assign cmp_wr = bus_wr & unit_sel[u];

			always @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					cmp_q <= `CCO_CMP_RESET;
				end else if (cmp_wr) begin
					cmp_q <= PWDATA[CW-1:0];
				end
			end

			// Signed comparison of count and point
			assign count_eq = (CUR_COUNT == cmp_q);
			assign count_gt = ($signed(CUR_COUNT) > $signed(cmp_q));
			assign count_lt = ($signed(CUR_COUNT) < $signed(cmp_q));
			assign greater_d = count_gt;
			assign smaller_d = count_lt;

			// Match latches until its reset command, so a held flag cannot re-trigger
			assign match_d = ~unit_rst[u] & (count_eq | match_q);
			assign out_d = match_d & out_enable;
			assign event_d = match_d & ~match_q;

			// Flags settle together, so a new match never sees a stale neighbour
			always @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					greater_q <= 1'b0;
				end else begin
					greater_q <= greater_d;
				end
			end

			always @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					smaller_q <= 1'b0;
				end else begin
					smaller_q <= smaller_d;
				end
			end

			always @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					match_q <= 1'b0;
				end else begin
					match_q <= match_d;
				end
			end

			always @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					MATCH_OUT[u] <= 1'b0;
				end else begin
					MATCH_OUT[u] <= out_d;
				end
			end

			always @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					MATCH_EVENT[u] <= 1'b0;
				end else begin
					MATCH_EVENT[u] <= event_d;
				end
			end

			assign match_rise[u] = event_d;
			assign greater_flag[u] = greater_q;
			assign smaller_flag[u] = smaller_q;
			assign match_flag[u] = match_q;
			assign cmp_point[u*CW +: CW] = cmp_q;
		end
	endgenerate

	// ****************************************
	// Preset on match
	// ****************************************
	wire load_req;

	assign load_req = preset_on_match & match_rise[0] & ~EXT_PRESET_DETECTED;

	// Only unit 1 feeds the load; a held match gives no new rising edge
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PRESET_LOAD <= 1'b0;
		end else begin
			PRESET_LOAD <= load_req;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	wire [`CCO_ST_W-1:0] status;
	wire [CW-1:0] cmp1_word;
	wire [CW-1:0] cmp2_word;
	wire rd_setup;
	reg [31:0] rd_word;

	assign cmp1_word = cmp_point[CW-1:0];
	assign cmp2_word = cmp_point[2*CW-1:CW];
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

	assign status[`CCO_ST_GREATER1] = greater_flag[0];
	assign status[`CCO_ST_MATCH1] = match_flag[0];
	assign status[`CCO_ST_SMALLER1] = smaller_flag[0];
	assign status[`CCO_ST_GREATER2] = greater_flag[1];
	assign status[`CCO_ST_MATCH2] = match_flag[1];
	assign status[`CCO_ST_SMALLER2] = smaller_flag[1];
	assign status[`CCO_ST_EXT_DET] = EXT_PRESET_DETECTED;

	// Read mux; detect-clear is write-only and reads back as zero
	always @* begin
		rd_word = `CCO_ZERO32;
		case (PADDR)
			`CCO_OFS_CTRL: begin
				rd_word[`CCO_CTRL_W-1:0] = ctrl_q;
			end
			`CCO_OFS_STATUS: begin
				rd_word[`CCO_ST_W-1:0] = status;
			end
			`CCO_OFS_CMP1: begin
				rd_word[CW-1:0] = cmp1_word;
			end
			`CCO_OFS_CMP2: begin
				rd_word[CW-1:0] = cmp2_word;
			end
			`CCO_OFS_PRESET: begin
				rd_word[CW-1:0] = PRESET_VALUE;
			end
			`CCO_OFS_COUNT: begin
				rd_word[CW-1:0] = CUR_COUNT;
			end
			default: begin
				rd_word = `CCO_ZERO32;
			end
		endcase
	end

	// Captured at setup so the access phase sees a steady word
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA <= `CCO_ZERO32;
		end else if (rd_setup) begin
			PRDATA <= rd_word;
		end
	end

	// bus_rd kept for clarity of decode; read data is latched in setup
	wire unused_rd;
	assign unused_rd = bus_rd;

endmodule // cco_compare_out

/* testbench/cco_compare_out_properties.sv */
// Checker for the compare output stage, bound to its top module.
// Assumes CTRL and CMP registers change only by APB writes.
`include "cco_map.vh"
module cco_props #(parameter CW = 32) (
	input wire CORE_CLK,
	input wire RESETN,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [CW-1:0] CUR_COUNT,
	input wire EXT_PRESET_DETECTED,
	input wire EXT_PRESET_DETECT_CLEAR,
	input wire PRESET_LOAD,
	input wire [1:0] MATCH_OUT,
	input wire [1:0] MATCH_EVENT
);
	logic [CW-1:0] cmp1_q, cmp2_q;
	logic [4:0] ctrl_q;
	logic [1:0] flag_q, prev_q, out_q;
	wire wr = PSEL && PENABLE && PWRITE;
	wire [1:0] eq = {CUR_COUNT == cmp2_q, CUR_COUNT == cmp1_q};
	// Match latches until its reset command
	wire [1:0] hit = ~ctrl_q[1:0] & (eq | flag_q);
	// Shadow copy of the written setup, so outputs tie back to their causes
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			{cmp1_q, cmp2_q, ctrl_q, flag_q, prev_q, out_q} <= '0;
		end else begin
			if (wr && PADDR == `CCO_OFS_CMP1) cmp1_q <= PWDATA;
			if (wr && PADDR == `CCO_OFS_CMP2) cmp2_q <= PWDATA;
			if (wr && PADDR == `CCO_OFS_CTRL) ctrl_q <= PWDATA[4:0];
			flag_q <= hit;
			prev_q <= flag_q;
			out_q <= hit & {2{ctrl_q[2]}};
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	sequence s_unit1_rise;
		flag_q[0] && !prev_q[0];
	endsequence
	sequence s_release1;
		$fell(ctrl_q[0]) && eq[0];
	endsequence
	chk_out_gate: assert property (MATCH_OUT == out_q)
		else $error("match output wrong");
	chk_event_edge: assert property (MATCH_EVENT == (flag_q & ~prev_q))
		else $error("match event wrong");
	chk_reset_hold: assert property (ctrl_q[0] |=> !MATCH_OUT[0] && !MATCH_EVENT[0])
		else $error("match not held off");
	chk_release_set: assert property (s_release1 |=> MATCH_EVENT[0])
		else $error("no match after release");
	chk_preset_cause: assert property (PRESET_LOAD == (MATCH_EVENT[0] && $past(ctrl_q[3]) &&
		!$past(EXT_PRESET_DETECTED))) else $error("preset load wrong");
	chk_load_rise: assert property (PRESET_LOAD |-> s_unit1_rise)
		else $error("load without rise");
	chk_unit2_noload: assert property (MATCH_EVENT[1] && !MATCH_EVENT[0] |-> !PRESET_LOAD)
		else $error("unit 2 loaded preset");
	chk_det_clear: assert property (wr && PADDR == `CCO_OFS_CTRL && PWDATA[4] |=>
		EXT_PRESET_DETECT_CLEAR ##1 !EXT_PRESET_DETECT_CLEAR) else $error("detect clear pulse wrong");
	chk_reset_quiet: assert property ($rose(RESETN) |-> MATCH_OUT == 2'h0 && !PRESET_LOAD)
		else $error("outputs not quiet after reset");
endmodule // cco_props
bind cco_compare_out cco_props #(.CW(CW)) u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .CUR_COUNT(CUR_COUNT),
	.EXT_PRESET_DETECTED(EXT_PRESET_DETECTED), .EXT_PRESET_DETECT_CLEAR(EXT_PRESET_DETECT_CLEAR),
	.PRESET_LOAD(PRESET_LOAD), .MATCH_OUT(MATCH_OUT), .MATCH_EVENT(MATCH_EVENT));

/* testbench/cco_engine.sv */
// Counting engine model: holds the count and the phase Z detected flag.
// Assumes the bench steers the count and raises phase Z events.
module cco_engine (
	input wire clk,
	input wire rst_n,
	input wire ld_en,
	input wire [31:0] ld_val,
	input wire z_pulse,
	input wire preset_load,
	input wire [31:0] preset_value,
	input wire det_clr,
	output logic [31:0] count,
	output logic det
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 32'h0;
			det <= 1'b0;
		end else begin
			if (preset_load) count <= preset_value;
			else if (ld_en) count <= ld_val;
			if (det_clr) det <= 1'b0;
			else if (z_pulse) det <= 1'b1;
		end
	end
endmodule // cco_engine

/* testbench/tb_cco_compare_out.sv */
// Self-checking bench of the compare output stage.
// Assumes an APB master here and the engine model on the count side.
`include "cco_map.vh"
module tb_cco_compare_out;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD_CYC = 20; // Stands in for 2ms; design has no minimum
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, ld = 0, z = 0, pready, perr, det, dclr, pload;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, ldv = 32'h0, prdata, pv, cnt, v;
	logic [31:0] c1 = 32'hFFFF_FF00, c2 = 32'h0000_0100;
	logic [1:0] mout, mev;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [15:0] lf = 16'hFF65;
	int mismatches = 0, check_count = 0;
	initial forever #5 clk = ~clk;
	cco_compare_out #(.CW(32)) dut (.CORE_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .CUR_COUNT(cnt),
		.EXT_PRESET_DETECTED(det), .EXT_PRESET_DETECT_CLEAR(dclr), .PRESET_LOAD(pload), .PRESET_VALUE(pv),
		.MATCH_OUT(mout), .MATCH_EVENT(mev));
	cco_engine eng (.clk(clk), .rst_n(rstn), .ld_en(ld), .ld_val(ldv), .z_pulse(z), .preset_load(pload),
		.preset_value(pv), .det_clr(dclr), .count(cnt), .det(det));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Expected STATUS word from count, reset commands and detected flag
	function automatic logic [32:0] st(input logic signed [31:0] s, input logic [1:0] r, input logic d);
		return {26'h0, d, s < $signed(c2), s == $signed(c2) && !r[1], s > $signed(c2),
			s < $signed(c1), s == $signed(c1) && !r[0], s > $signed(c1)};
	endfunction
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
		exp_q.push_back(x);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 0;
		pen <= 0;
	endtask
	task setc(input logic [31:0] x);
		@(posedge clk);
		ld <= 1;
		ldv <= x;
		@(posedge clk);
		ld <= 0;
		repeat (2) @(posedge clk);
	endtask
	task wrap_up;
		if (mismatches == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Result watcher: error flag always, read data on reads only
	always @(posedge clk) begin
		if (psel && pen && pready === 1'b1) begin
			e = exp_q.pop_front();
			check_count++;
			if ({perr, pwr ? 32'h0 : prdata} !== e) begin
				mismatches++;
				$display("[FAIL] %0t got %h exp %h", $time, {perr, pwr ? 32'h0 : prdata}, e);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		apb(1, `CCO_OFS_CMP1, c1, 33'h0);
		apb(1, `CCO_OFS_CMP2, c2, 33'h0);
		for (int k = 0; k < 16; k++) begin
			lf = lfsr(lf);
			v = k[1] ? (k[0] ? {{16{lf[15]}}, lf} : c2) : (k[0] ? c1 : c1 - 1);
			setc(v);
			apb(1, `CCO_OFS_CTRL, (k >= 8) ? 32'h7 : 32'h3, 33'h0);
			apb(1, `CCO_OFS_CTRL, (k >= 8) ? 32'h4 : 32'h0, 33'h0);
			apb(0, `CCO_OFS_STATUS, 32'h0, st(v, 2'h0, 1'b0));
		end
		setc(c1);
		apb(1, `CCO_OFS_CTRL, 32'h7, 33'h0);
		apb(1, `CCO_OFS_CTRL, 32'h5, 33'h0);
		repeat (HOLD_CYC) @(posedge clk);
		apb(0, `CCO_OFS_STATUS, 32'h0, st(c1, 2'h1, 1'b0));
		apb(1, `CCO_OFS_CTRL, 32'h4, 33'h0);
		apb(0, `CCO_OFS_STATUS, 32'h0, st(c1, 2'h0, 1'b0));
		apb(1, `CCO_OFS_PRESET, 32'h0000_5678, 33'h0);
		setc(c1 - 1);
		apb(1, `CCO_OFS_CTRL, 32'hD, 33'h0);
		apb(1, `CCO_OFS_CTRL, 32'hC, 33'h0);
		setc(c1);
		apb(0, `CCO_OFS_COUNT, 32'h0, {1'b0, 32'h0000_5678});
		setc(c1);
		apb(0, `CCO_OFS_COUNT, 32'h0, {1'b0, c1});
		apb(1, `CCO_OFS_PRESET, 32'h0000_1234, 33'h0);
		repeat (HOLD_CYC) @(posedge clk);
		setc(c1 - 1);
		apb(1, `CCO_OFS_CTRL, 32'hD, 33'h0);
		apb(1, `CCO_OFS_CTRL, 32'hC, 33'h0);
		setc(c1);
		apb(0, `CCO_OFS_COUNT, 32'h0, {1'b0, 32'h0000_1234});
		setc(c2);
		apb(0, `CCO_OFS_COUNT, 32'h0, {1'b0, c2});
		@(posedge clk);
		z <= 1;
		@(posedge clk);
		z <= 0;
		setc(c1 - 1);
		apb(1, `CCO_OFS_CTRL, 32'hD, 33'h0);
		apb(1, `CCO_OFS_CTRL, 32'hC, 33'h0);
		setc(c1);
		apb(0, `CCO_OFS_COUNT, 32'h0, {1'b0, c1});
		apb(1, `CCO_OFS_CTRL, 32'h1E, 33'h0);
		apb(1, `CCO_OFS_CTRL, 32'h4, 33'h0);
		repeat (3) @(posedge clk);
		apb(0, `CCO_OFS_STATUS, 32'h0, st(c1, 2'h0, 1'b0));
		apb(0, 12'h020, 32'h0, {1'b1, 32'h0});
		apb(1, `CCO_OFS_STATUS, 32'hFF, {1'b1, 32'h0});
		@(posedge clk);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		apb(0, `CCO_OFS_STATUS, 32'h0, {1'b0, 32'h0000_0012});
		wrap_up();
	end
endmodule // tb_cco_compare_out
